// ---- sim/ready_monitor.sv ----
`timescale 1ns/1ps
module ready_monitor (
    // open-drain pin from the sequencer
    input wire logic ready_n_o,
    input wire logic ready_n_oe_o,
    // level the controller sees
    output logic rdy_line
);
    // external pull-up: a released pin reads high, meaning not ready
    assign rdy_line = ready_n_oe_o ? ready_n_o : 1'b1;
endmodule

// ---- sim/triple_rail_power_sequencer_assertions.sv ----
`timescale 1ns/1ps
module rail_seq_assertions (
    // watched ports
    input wire logic clk_i, rst_i, shutdown_n_i, ref_ok_i, main_reg_i, main_ok_i,
    input wire logic neg_up_i, neg_ok_i, pos_up_i, pos_ok_i, cyc_i, stb_i, ack_o,
    input wire logic ref_en_o, main_en_o, main_softstart_o, neg_en_o, pos_en_o,
    input wire logic ready_n_o, ready_n_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // six cycles covers the two-stage sync plus state and enable registers
    wire base_ok = shutdown_n_i && ref_ok_i && main_ok_i;
    sequence neg_go_s;
        (main_en_o && main_reg_i && base_ok)[*6];
    endsequence
    sequence pos_go_s;
        (neg_en_o && neg_up_i && neg_ok_i && base_ok)[*6];
    endsequence
    sequence rdy_go_s;
        (pos_en_o && pos_up_i && pos_ok_i && neg_ok_i && base_ok)[*6];
    endsequence
    ref_first_a: assert property (main_en_o |-> ref_en_o) else $error("main on without ref");
    rail_order_a: assert property (pos_en_o |-> neg_en_o && main_en_o) else $error("rail order");
    soft_start_a: assert property (main_softstart_o |-> main_en_o && !neg_en_o) else $error("softstart");
    neg_step_a: assert property (neg_go_s |-> neg_en_o) else $error("neg pump late");
    pos_step_a: assert property (pos_go_s |-> pos_en_o) else $error("pos pump late");
    ready_step_a: assert property (rdy_go_s |-> ready_n_oe_o) else $error("ready late");
    ready_cause_a: assert property (ready_n_oe_o |-> pos_en_o && !ready_n_o) else $error("ready pin");
    ref_fault_a: assert property ((!ref_ok_i)[*6] |-> !main_en_o) else $error("ref fault");
    main_fault_a: assert property ((!main_ok_i)[*6] |-> !neg_en_o) else $error("main fault");
    neg_fault_a: assert property ((!neg_ok_i)[*6] |-> !pos_en_o) else $error("neg fault");
    pos_fault_a: assert property ((!pos_ok_i)[*6] |-> !ready_n_oe_o) else $error("pos fault");
    shut_off_a: assert property ((!shutdown_n_i)[*6] |-> !ref_en_o && !main_en_o && !neg_en_o && !pos_en_o)
        else $error("shutdown");
    sync_delay_a: assert property ($rose(shutdown_n_i) && !ref_en_o |=> !ref_en_o) else $error("unsynced");
    bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("ack timing");
endmodule

bind triple_rail_power_sequencer rail_seq_assertions u_chk (.*);

// ---- sim/triple_rail_power_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`include "rail_seq_consts.svh"
module triple_rail_power_sequencer_tb_top;
    import rail_seq_pkg::*;
    logic clk_i = 0, rst_i = 1, shutdown_n_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0] flg = 8'h00, adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ref_en_o, main_en_o, main_softstart_o, neg_en_o, pos_en_o, ready_n_o, ready_n_oe_o;
    logic ack_o, irq_o, rdy_line;
    ss_phase_t main_ilim_phase_o;
    wire [4:0] en = {ref_en_o, main_en_o, neg_en_o, pos_en_o, ready_n_oe_o};
    int n_fail = 0, n_checks = 0, seed = 87, k;
    // rail flags packed as up/ok pairs, reference first
    triple_rail_power_sequencer u_dut (.*, .ref_up_i(flg[7]), .ref_ok_i(flg[6]), .main_reg_i(flg[5]),
        .main_ok_i(flg[4]), .neg_up_i(flg[3]), .neg_ok_i(flg[2]), .pos_up_i(flg[1]), .pos_ok_i(flg[0]));
    ready_monitor u_mon (.ready_n_o(ready_n_o), .ready_n_oe_o(ready_n_oe_o), .rdy_line(rdy_line));
    initial forever #4 clk_i = ~clk_i;
    // stage n: first n of ref, main, neg, pos, ready are on
    function automatic logic [4:0] exp_en(input int n);
        return ~(5'h1f >> n);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wait_en(input int n);
        for (int i = 0; i < 60 && en !== exp_en(n); i++) @(posedge clk_i);
        chk(en, exp_en(n), "enables");
        chk(rdy_line, n != 5, "ready line");
    endtask
    // classic cycle: hold everything until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        chk(ack_o, 1, "ack");
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        wait_en(1);
        flg <= 8'hc0;
        wait_en(2);
        chk(main_softstart_o, 1, "softstart");
        chk(main_ilim_phase_o, 0, "ilim start");
        flg <= 8'hf0;
        wait_en(3);
        chk(main_ilim_phase_o, `SS_LAST_PHASE, "ilim");
        flg <= 8'hfc;
        wait_en(4);
        flg <= 8'hff;
        wait_en(5);
        wb(1, `OFS_IRQ_MASK, 32'h7);
        wb(0, `OFS_IRQ_STAT, 32'h0);
        chk(rd, 32'h5, "irq events");
        chk(irq_o, 1, "irq raised");
        wb(1, `OFS_IRQ_STAT, 32'h5);
        chk(irq_o, 0, "irq cleared");
        wb(0, `OFS_STATUS, 32'h0);
        chk(rd, 32'hfff, "status");
        wb(0, 8'h10, 32'h0);
        chk(rd, 32'h0, "unmapped");
        // walk every rail, then random ones
        for (int i = 0; i < 10; i++) begin
            k = (i < 4) ? i : ($random(seed) & 3);
            flg[7 - 2 * k -: 2] <= 2'b00;
            wait_en(k + 1);
            flg <= 8'hff;
            wait_en(5);
        end
        wb(0, `OFS_IRQ_STAT, 32'h0);
        chk(rd[1], 1, "ready fell event");
        wb(1, `OFS_IRQ_MASK, 32'h0);
        chk(irq_o, 0, "irq masked");
        shutdown_n_i <= 0;
        wait_en(0);
        shutdown_n_i <= 1;
        wait_en(5);
        // reset in mid-run drops every rail and the sequence starts over
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        chk(en, 5'h00, "reset rails");
        rst_i <= 0;
        wait_en(5);
        final_report;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        final_report;
    end
endmodule

// ---- src/rail_seq_consts.svh ----
`ifndef RAIL_SEQ_CONSTS_SVH
`define RAIL_SEQ_CONSTS_SVH

// wishbone register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0c

// control register fields
`define CTRL_SW_EN_BIT 0
`define CTRL_RESET_VAL 32'h0000_0001

// interrupt status fields
`define IRQ_READY_BIT 0
`define IRQ_FAULT_BIT 1
`define IRQ_SEQ_DONE_BIT 2
`define IRQ_WIDTH 3
`define IRQ_MASK_RESET 3'h0

// soft-start timing: 1 ms per phase at 125 MHz
`define CLK_FREQ_HZ 125000000
`define SS_PHASE_TIME_US 1000
`define SS_PHASE_CYCLES ((`CLK_FREQ_HZ / 1000000) * `SS_PHASE_TIME_US)
`define SS_LAST_PHASE 2'h3

`endif

// ---- src/rail_seq_pkg.sv ----
package rail_seq_pkg;

    // sequencer states, gray-coded along the power-up path
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_REF = 3'b001,
        ST_MAIN = 3'b011,
        ST_NEG = 3'b010,
        ST_POS = 3'b110,
        ST_READY = 3'b111
    } seq_state_t;

    typedef logic [1:0] ss_phase_t;

endpackage

// ---- src/triple_rail_power_sequencer.sv ----
// Summary of operation
// - start-up enables reference before any converter
// - then main boost with soft-start active
// - negative pump only after main regulates
// - positive pump after negative below 110mV
// - ready low when positive above 1.125V
// - ready open-drain, released on any fault
// - after ready, rail fault releases ready
// - reference faulted below 1.05V
// - main boost faulted below 1.1V
// - negative pump faulted at 130mV threshold
// - positive pump faulted below 1.11V
// - fault disables later rails until recovery
// - earlier rails stay on during fault
// - shutdown low disables all, high restarts
// - soft-start four quarter steps each 1ms
`timescale 1ns/1ps
`include "rail_seq_consts.svh"

module triple_rail_power_sequencer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins and comparator flags (asynchronous)
    input wire logic shutdown_n_i,
    input wire logic ref_up_i,
    input wire logic ref_ok_i,
    input wire logic main_reg_i,
    input wire logic main_ok_i,
    input wire logic neg_up_i,
    input wire logic neg_ok_i,
    input wire logic pos_up_i,
    input wire logic pos_ok_i,
    // rail enables
    output logic ref_en_o,
    output logic main_en_o,
    output logic main_softstart_o,
    output rail_seq_pkg::ss_phase_t main_ilim_phase_o,
    output logic neg_en_o,
    output logic pos_en_o,
    // open-drain ready pin
    // ready_n_o is always low; ready_n_oe_o decides whether the pin is pulled
    output logic ready_n_o,
    output logic ready_n_oe_o,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // interrupt
    // level, high while an unmasked status bit is set
    output logic irq_o
);
    import rail_seq_pkg::*;

    localparam int NFLAG = 9;
    // last count value of a soft-start phase; one phase spans a millisecond
    // the counter is 32 bits wide so a faster clock only needs the macro changed
    localparam logic [31:0] PHASE_LAST = 32'(`SS_PHASE_CYCLES - 1);

    // raw pin levels; every one may change at any moment relative to clk_i
    logic [NFLAG-1:0] pins_raw;
    assign pins_raw = {shutdown_n_i, ref_up_i, ref_ok_i, main_reg_i, main_ok_i,
                       neg_up_i, neg_ok_i, pos_up_i, pos_ok_i};

    // two-stage synchronisers; stage one feeds only stage two
    // reset clears them to zero, which reads as shutdown and all rails bad,
    // so nothing can start in the two cycles before real levels arrive
    logic [NFLAG-1:0] sync_a;
    logic [NFLAG-1:0] sync_b;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
        end
    end

    logic shutdown_n_ok, ref_up, ref_ok, main_reg, main_ok, neg_up, neg_ok, pos_up, pos_ok;
    // ok flags are the fault comparators: ref >1.05V, fb >1.1V, fbn <130mV, fbp >1.11V
    // up flags are power-up thresholds: main reg, fbn <110mV, fbp >1.125V
    // shutdown_n_ok is the pin after synchronising: high means run
    assign {shutdown_n_ok, ref_up, ref_ok, main_reg, main_ok, neg_up, neg_ok, pos_up, pos_ok} = sync_b;

    // control register bit gates operation along with the pin
    // clearing it acts like the pin going low: a full restart follows
    logic sw_en;
    logic run;
    assign run = shutdown_n_ok && sw_en;

    // sequencer and soft-start state
    // ss_done remembers that regulation was reached in this run
    seq_state_t state, next_state;
    ss_phase_t phase, next_phase;
    logic [31:0] ss_cnt, next_ss_cnt;
    logic ss_done, next_ss_done;

    always_comb begin
        next_state = state;
        next_phase = phase;
        next_ss_cnt = ss_cnt;
        next_ss_done = ss_done;
        case (state)
            ST_OFF: begin
                // everything rewinds while off so the next start is a fresh sequence
                next_phase = 2'h0;
                next_ss_cnt = '0;
                next_ss_done = 1'b0;
                if (run) begin
                    next_state = ST_REF;
                end
            end
            ST_REF: begin
                // nothing but the reference runs until it has come up
                if (ref_up) begin
                    next_state = ST_MAIN;
                end
            end
            ST_MAIN: begin
                // quarter steps of current limit until regulation or full
                // regulation ends soft-start at once, whichever phase is active
                // phase 3 is the full limit and also the last; the counter then idles
                if (main_reg) begin
                    next_state = ST_NEG;
                    next_ss_done = 1'b1;
                end else if (!ss_done && phase != `SS_LAST_PHASE) begin
                    if (ss_cnt == PHASE_LAST) begin
                        next_ss_cnt = '0;
                        next_phase = phase + 2'h1;
                    end else begin
                        next_ss_cnt = ss_cnt + 32'h1;
                    end
                end
            end
            ST_NEG: begin
                // main keeps its full limit from here on
                if (neg_up) begin
                    next_state = ST_POS;
                end
            end
            ST_POS: begin
                // both pumps run; ready waits on the positive rail
                if (pos_up) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                // stay here; only the fault and shutdown checks below can leave
                next_state = ST_READY;
            end
            default: begin
                // catches the two unused codes and returns to OFF
                next_state = ST_OFF;
            end
        endcase
        // fault supervision: fall back to the faulted rail, earlier rails stay
        // the earliest bad rail decides; a fault seen while still climbing to that
        // rail's own state is ignored, since its enable is what is being waited on
        // the positive rail's own fault releases ready but keeps the pump running
        if (state != ST_OFF) begin
            if (!ref_ok && state != ST_REF) begin
                next_state = ST_REF;
            end else if (!main_ok && (state == ST_NEG || state == ST_POS || state == ST_READY)) begin
                next_state = ST_MAIN;
            end else if (!neg_ok && (state == ST_POS || state == ST_READY)) begin
                next_state = ST_NEG;
            end else if (!pos_ok && state == ST_READY) begin
                next_state = ST_POS;
            end
        end
        // shutdown overrides everything
        // a low pin or a cleared enable bit both land in OFF, which rewinds soft-start
        if (!run) begin
            next_state = ST_OFF;
        end
    end

    // state registers; synchronous reset returns to OFF with soft-start rewound
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_OFF;
            phase <= 2'h0;
            ss_cnt <= '0;
            ss_done <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            ss_cnt <= next_ss_cnt;
            ss_done <= next_ss_done;
        end
    end

    // rail pattern of a state, as {ref, main, neg, pos, ready}
    // each pattern holds all of the one before it, so falling back to a
    // faulted rail's state switches off exactly the rails after it
    function automatic logic [4:0] rails_for(input seq_state_t st);
        case (st)
            ST_OFF: rails_for = 5'h00;
            ST_REF: rails_for = 5'h10;
            ST_MAIN: rails_for = 5'h18;
            ST_NEG: rails_for = 5'h1c;
            ST_POS: rails_for = 5'h1e;
            ST_READY: rails_for = 5'h1f;
            default: rails_for = 5'h00;
        endcase
    endfunction

    // registered rail enables; recovery re-enters the sequence in order
    // decoding next_state lets the enables change on the same edge as state
    logic [4:0] rail_set;
    logic next_ref_en, next_main_en, next_neg_en, next_pos_en, next_rdy;
    always_comb begin
        rail_set = rails_for(next_state);
        next_ref_en = rail_set[4];
        next_main_en = rail_set[3];
        next_neg_en = rail_set[2];
        next_pos_en = rail_set[1];
        next_rdy = rail_set[0];
    end

    // enables and the ready flag from flip-flops, so the pins never glitch
    logic rdy;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_en_o <= 1'b0;
            main_en_o <= 1'b0;
            neg_en_o <= 1'b0;
            pos_en_o <= 1'b0;
            rdy <= 1'b0;
        end else begin
            ref_en_o <= next_ref_en;
            main_en_o <= next_main_en;
            neg_en_o <= next_neg_en;
            pos_en_o <= next_pos_en;
            rdy <= next_rdy;
        end
    end

    // soft-start stays active until regulation; once reached it never re-ramps this run
    // a fault that drops back to main keeps the full limit: the rail was already up
    assign main_softstart_o = main_en_o && !ss_done;
    assign main_ilim_phase_o = ss_done ? `SS_LAST_PHASE : phase;

    // open-drain: drive low only when ready, otherwise high impedance
    // the pin level itself is never driven high; a pull-up must supply it
    assign ready_n_o = 1'b0;
    assign ready_n_oe_o = rdy;

    // events for interrupt status
    // one-cycle delay of ready for edge detection; zero after reset matches idle
    logic rdy_d;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_d <= 1'b0;
        end else begin
            rdy_d <= rdy;
        end
    end
    // edges of the registered ready flag; a drop means a fault or a shutdown
    // seq done marks main reaching regulation, the end of soft-start
    logic [`IRQ_WIDTH-1:0] events;
    always_comb begin
        events = '0;
        events[`IRQ_READY_BIT] = rdy && !rdy_d;
        events[`IRQ_FAULT_BIT] = !rdy && rdy_d;
        events[`IRQ_SEQ_DONE_BIT] = (state == ST_MAIN) && (next_state == ST_NEG);
    end

    // wishbone decode; one wait state keeps ack registered
    // a request is taken only while ack is low, so a held strobe is not taken twice
    // writes honour only sel_i[0]: every field sits in the low byte
    logic wr_stb, rd_stb;
    assign wr_stb = cyc_i && stb_i && we_i && !ack_o;
    assign rd_stb = cyc_i && stb_i && !we_i && !ack_o;

    // status layout: synced flags above the three-bit state code
    function automatic logic [31:0] status_word(input seq_state_t st, input logic [8:0] flags);
        status_word = {20'h0, flags, st};
    endfunction

    // sticky event bits, write one to clear; mask has the same layout
    logic [`IRQ_WIDTH-1:0] irq_stat, next_irq_stat;
    logic [`IRQ_WIDTH-1:0] irq_mask, next_irq_mask;
    logic next_sw_en;
    logic next_ack;
    logic next_irq;
    logic [31:0] next_dat;
    // register file next values; writes use the low byte lane only
    always_comb begin
        next_sw_en = sw_en;
        // ack answers one cycle after a request and drops in the cycle after
        next_ack = cyc_i && stb_i && !ack_o;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_dat = dat_o;
        // write decode; unmapped offsets are ignored
        if (wr_stb && sel_i[0]) begin
            case (adr_i)
                `OFS_CTRL: next_sw_en = dat_i[`CTRL_SW_EN_BIT];
                `OFS_IRQ_STAT: next_irq_stat = irq_stat & ~dat_i[`IRQ_WIDTH-1:0];
                `OFS_IRQ_MASK: next_irq_mask = dat_i[`IRQ_WIDTH-1:0];
                default: next_irq_stat = irq_stat;
            endcase
        end
        // set wins over a clear in the same cycle
        next_irq_stat = next_irq_stat | events;
        // read data is latched with ack and then held until the next read
        if (rd_stb) begin
            case (adr_i)
                `OFS_CTRL: next_dat = {31'h0, sw_en};
                `OFS_STATUS: next_dat = status_word(state, sync_b);
                `OFS_IRQ_STAT: next_dat = {29'h0, irq_stat};
                `OFS_IRQ_MASK: next_dat = {29'h0, irq_mask};
                default: next_dat = 32'h0;
            endcase
        end
        // level interrupt from the values the registers are about to take,
        // so a clear and its effect on irq_o land on the same edge
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // register file and bus outputs; only copies of the next values here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_en <= 1'(`CTRL_RESET_VAL >> `CTRL_SW_EN_BIT);
            irq_stat <= '0;
            irq_mask <= `IRQ_MASK_RESET;
            dat_o <= 32'h0;
            ack_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            sw_en <= next_sw_en;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            dat_o <= next_dat;
            ack_o <= next_ack;
            irq_o <= next_irq;
        end
    end

endmodule
